//--- csau_unit.sv
// What this block does
// - Add: A addend, B augend, sum to B
// - Subtract: A subtrahend, B minuend, into B
// - Binary columns are full adders
// - Subtract adds ones complement, right to left
// - Forced first carry, then propagated carry
// - Binary subtract ends on B word mark
// - Equal lengths combine high-order characters too
// - Longer A stops at B high end
// - Shorter A supplies complemented zeros
// - Final carry dropped, no overflow, no spill
// - Signs from units zones select add type
// - Sign is two-bit zone, four codes
// - Equal signs: true add, keep B zone
// - Clear B zones, ignore A zones, except units
// - Unequal signs: add tens complement of A
// - Record high-order carry of complement add
// - Carry: finish with normalized B sign
// - No carry: recomplement B, invert sign
// - Normalized plus 01, minus 10
// - True-add carry past B sets overflow, else unchanged
`timescale 1ns/1ps
`default_nettype none
module csau_unit (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    start,
	input  wire csau_pkg::csau_cmd_t     cmd,
	input  wire logic                    ovf_clr,
	input  wire csau_pkg::csau_mem_rsp_t mem_rsp,
	output csau_pkg::csau_mem_req_t      mem_req,
	output logic                         busy,
	output logic                         done,
	output logic                         ovf
);
	import csau_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	csau_state_t       state_q, state_d;
	csau_op_t          op_q;
	logic [ADDR_W-1:0] a_addr_q;
	logic [ADDR_W-1:0] b_addr_q;
	logic [ADDR_W-1:0] units_addr_q;
	csau_char_t        a_char_q;
	logic              a_rd_q;
	logic              a_end_q;
	logic              first_q;
	logic              carry_q;
	logic              recomp_q;
	logic              comp_q;
	logic              sign_a_q;
	logic              res_minus_q;
	logic [3:0]        units_digit_q;
	logic              ovf_q;
	logic              done_q;
	csau_mem_req_t     mem_q, mem_d;

	// ---------------------------------------------------------------
	// Sign decode and column arithmetic
	// ---------------------------------------------------------------
	wire logic       is_dec    = (op_q == op_decimal_add);
	wire logic       is_sub    = (op_q == binary_subtract_opcode);
	wire csau_char_t b_char    = mem_rsp.data;
	wire logic       b_wm      = mem_rsp.wm;
	wire logic       sign_b    = (b_char.zone == ZONE_MINUS);
	wire logic       a_minus   = (mem_rsp.data.zone == ZONE_MINUS);
	wire logic       comp_now  = first_q ? (sign_a_q ^ sign_b) : comp_q;
	wire logic       first_cin = recomp_q | is_sub | (is_dec & comp_now);
	wire logic       cin_eff   = first_q ? first_cin : carry_q;

	// Binary path: subtrahend goes in as its ones complement
	wire logic [CHAR_W-1:0] bin_a = is_sub ? ~a_char_q : a_char_q;
	wire logic [CHAR_W-1:0] bin_b = b_char;
	logic      [CHAR_W-1:0] bin_sum;
	logic      [CHAR_W:0]   bin_c;

	assign bin_c[0] = cin_eff;
	genvar gi;
	generate
		for (gi = 0; gi < CHAR_W; gi++) begin : g_fa
			assign bin_sum[gi]  = bin_a[gi] ^ bin_b[gi] ^ bin_c[gi];
			assign bin_c[gi+1]  = (bin_a[gi] & bin_b[gi]) |
			                      (bin_c[gi] & (bin_a[gi] ^ bin_b[gi]));
		end
	endgenerate

	// Decimal path: recomplement reuses the digit adder as 0 - B
	wire logic [3:0] dec_a    = recomp_q ? b_char.digit : a_char_q.digit;
	wire logic [3:0] dec_b    = recomp_q ? DIGIT_ZERO : b_char.digit;
	wire logic       dec_comp = recomp_q | comp_now;
	logic      [3:0] dec_sum;
	logic            dec_cout;

	csau_dec_digit u_digit (
		.a    (dec_a),
		.b    (dec_b),
		.comp (dec_comp),
		.cin  (cin_eff),
		.sum  (dec_sum),
		.cout (dec_cout)
	);

	wire logic col_cout = is_dec ? dec_cout : bin_c[CHAR_W];

	// True add keeps the original B units zone; all other B zones clear
	wire logic [1:0] dec_zone = (first_q && !recomp_q && !comp_now) ?
	                            b_char.zone : ZONE_NONE;
	wire csau_char_t res_char = is_dec ? csau_char_t'({dec_zone, dec_sum}) :
	                                     csau_char_t'(bin_sum);

	wire logic [1:0] norm_zone = res_minus_q ? ZONE_MINUS : ZONE_PLUS;

	// End-of-field decisions, made in the write cycle on the B word mark
	wire logic last_col   = (state_q == ST_WRB) && b_wm;
	wire logic dec_fin    = is_dec && !recomp_q && !comp_now;       // true add ends here
	wire logic go_recomp  = is_dec && !recomp_q && comp_now && !dec_cout;
	wire logic go_sign    = is_dec && (recomp_q || (comp_now && dec_cout));
	wire logic set_ovf    = last_col && dec_fin && dec_cout;
	wire logic a_read_now = (state_q == ST_RDA) && !a_end_q && !recomp_q;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d = ST_RDA;
				end
			end
			ST_RDA:  state_d = ST_RDB;
			ST_RDB:  state_d = ST_CAPA;
			ST_CAPA: state_d = ST_WRB;
			ST_WRB: begin
				if (!b_wm) begin
					state_d = ST_RDA;
				end else if (go_recomp) begin
					state_d = ST_RDA;
				end else if (go_sign) begin
					state_d = ST_SIGN;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_SIGN: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	// ---------------------------------------------------------------
	// Memory request, registered so address and data leave flops
	// ---------------------------------------------------------------
	always_comb begin
		mem_d = '0;
		unique case (state_q)
			ST_RDA: begin
				if (a_read_now) begin
					mem_d.req  = 1'b1;
					mem_d.addr = a_addr_q;
				end
			end
			ST_RDB: begin
				mem_d.req  = 1'b1;
				mem_d.addr = b_addr_q;
			end
			ST_WRB: begin
				mem_d.req   = 1'b1;
				mem_d.we    = 1'b1;
				mem_d.addr  = b_addr_q;
				mem_d.wdata = res_char;
			end
			ST_SIGN: begin
				mem_d.req   = 1'b1;
				mem_d.we    = 1'b1;
				mem_d.addr  = units_addr_q;
				mem_d.wdata = csau_char_t'({norm_zone, units_digit_q});
			end
			default: mem_d = '0;
		endcase
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			mem_q   <= '0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			mem_q   <= mem_d;
			done_q  <= (state_q == ST_SIGN) ||
			           (last_col && !go_recomp && !go_sign);
		end
	end

	// Operand walk; the B address never steps past the word-marked character
	always_ff @(posedge clk) begin
		if (rst) begin
			op_q         <= op_binary_add;
			a_addr_q     <= '0;
			b_addr_q     <= '0;
			units_addr_q <= '0;
			a_rd_q       <= 1'b0;
			a_end_q      <= 1'b0;
			first_q      <= 1'b0;
			recomp_q     <= 1'b0;
		end else if (state_q == ST_IDLE && start) begin
			op_q         <= cmd.op;
			a_addr_q     <= cmd.a_addr;
			b_addr_q     <= cmd.b_addr;
			units_addr_q <= cmd.b_addr;
			a_end_q      <= 1'b0;
			first_q      <= 1'b1;
			recomp_q     <= 1'b0;
		end else begin
			// Held through CAPA, where the A response is finally taken
			if (state_q == ST_RDA) begin
				a_rd_q <= a_read_now;
			end
			if (state_q == ST_CAPA && a_rd_q && mem_rsp.wm) begin
				a_end_q <= 1'b1;
			end
			if (state_q == ST_WRB && !b_wm) begin
				b_addr_q <= b_addr_q - ADDR_STEP;
				if (!a_end_q) begin
					a_addr_q <= a_addr_q - ADDR_STEP;
				end
				first_q <= 1'b0;
			end else if (state_q == ST_WRB && go_recomp) begin
				b_addr_q <= units_addr_q;
				first_q  <= 1'b1;
				recomp_q <= 1'b1;
			end
		end
	end

	// Column data: A character (zero once A has ended), carry and signs
	always_ff @(posedge clk) begin
		if (rst) begin
			a_char_q      <= '0;
			carry_q       <= 1'b0;
			comp_q        <= 1'b0;
			sign_a_q      <= 1'b0;
			res_minus_q   <= 1'b0;
			units_digit_q <= '0;
		end else begin
			if (state_q == ST_CAPA) begin
				a_char_q <= a_rd_q ? mem_rsp.data : csau_char_t'('0);
				if (first_q && !recomp_q) begin
					sign_a_q <= a_minus;
				end
			end
			if (state_q == ST_WRB) begin
				carry_q <= col_cout;
				if (first_q) begin
					units_digit_q <= dec_sum;
				end
				if (first_q && !recomp_q) begin
					comp_q      <= comp_now;
					res_minus_q <= sign_b;
				end
				// One-character B: capture and invert fall in the same cycle
				if (go_recomp && b_wm) begin
					res_minus_q <= first_q ? !sign_b : !res_minus_q;
				end
			end
		end
	end

	// Overflow is sticky; a set in the clear cycle wins
	always_ff @(posedge clk) begin
		if (rst) begin
			ovf_q <= 1'b0;
		end else if (set_ovf) begin
			ovf_q <= 1'b1;
		end else if (ovf_clr) begin
			ovf_q <= 1'b0;
		end
	end

	assign mem_req = mem_q;
	assign busy    = (state_q != ST_IDLE);
	assign done    = done_q;
	assign ovf     = ovf_q;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_bsub_forced_carry;
		@(posedge clk) disable iff (rst)
		(state_q == ST_WRB && first_q && is_sub) |-> (cin_eff == 1'b1);
	endproperty
	a_bsub_forced_carry: assert property (p_bsub_forced_carry)
		else $error("binary subtract first column lacks forced carry");

	property p_carry_chain;
		@(posedge clk) disable iff (rst)
		(state_q == ST_WRB && !b_wm) ##4 (state_q == ST_WRB) |->
			(cin_eff == $past(col_cout, 4));
	endproperty
	a_carry_chain: assert property (p_carry_chain)
		else $error("column carry not passed to the next column");

	property p_write_to_b;
		@(posedge clk) disable iff (rst)
		(state_q == ST_WRB) |=> (mem_req.we && mem_req.addr == $past(b_addr_q));
	endproperty
	a_write_to_b: assert property (p_write_to_b)
		else $error("result not written to the B position");

	property p_bin_ends_on_wm;
		@(posedge clk) disable iff (rst)
		(state_q == ST_WRB && b_wm && !is_dec) |=> (state_q == ST_IDLE && done);
	endproperty
	a_bin_ends_on_wm: assert property (p_bin_ends_on_wm)
		else $error("binary operation did not end at B word mark");

	property p_bin_no_ovf;
		@(posedge clk) disable iff (rst)
		(state_q == ST_WRB && !is_dec && !ovf_clr) |=> (ovf_q == $past(ovf_q));
	endproperty
	a_bin_no_ovf: assert property (p_bin_no_ovf)
		else $error("binary operation changed overflow");

	property p_no_a_read_after_end;
		@(posedge clk) disable iff (rst)
		(state_q == ST_RDA && a_end_q) |=> !mem_req.req;
	endproperty
	a_no_a_read_after_end: assert property (p_no_a_read_after_end)
		else $error("A read after the A field ended");

	property p_sign_normalized;
		@(posedge clk) disable iff (rst)
		(state_q == ST_SIGN) |=> (mem_req.wdata.zone == ZONE_PLUS ||
		                          mem_req.wdata.zone == ZONE_MINUS);
	endproperty
	a_sign_normalized: assert property (p_sign_normalized)
		else $error("sign write not normalized");

	property p_upper_zones_clear;
		@(posedge clk) disable iff (rst)
		(state_q == ST_WRB && is_dec && !first_q) |=> (mem_req.wdata.zone == ZONE_NONE);
	endproperty
	a_upper_zones_clear: assert property (p_upper_zones_clear)
		else $error("decimal result zone not cleared");

	property p_true_add_keeps_zone;
		@(posedge clk) disable iff (rst)
		(state_q == ST_WRB && is_dec && first_q && !recomp_q && !comp_now) |=>
			(mem_req.wdata.zone == $past(b_char.zone));
	endproperty
	a_true_add_keeps_zone: assert property (p_true_add_keeps_zone)
		else $error("true add lost B units zone");

	property p_recomp_on_no_carry;
		@(posedge clk) disable iff (rst)
		(last_col && is_dec && !recomp_q && comp_now && !dec_cout) |=>
			(recomp_q && first_q && state_q == ST_RDA);
	endproperty
	a_recomp_on_no_carry: assert property (p_recomp_on_no_carry)
		else $error("missing recomplement pass");

	property p_ovf_sticky;
		@(posedge clk) disable iff (rst)
		(ovf_q && !ovf_clr) |=> ovf_q;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky)
		else $error("overflow dropped without a clear");

	property p_done_pulse;
		@(posedge clk) disable iff (rst)
		done |=> !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done held longer than one cycle");

endmodule
`default_nettype wire

//--- csau_pkg.sv
`default_nettype none
package csau_pkg;

	// ---------------------------------------------------------------
	// Sizes and character layout
	// ---------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int CHAR_W = 6;

	localparam logic [1:0] ZONE_NONE  = 2'h0;
	localparam logic [1:0] ZONE_PLUS  = 2'h1;
	localparam logic [1:0] ZONE_MINUS = 2'h2;

	localparam logic [3:0] DIGIT_ZERO = 4'h0;
	localparam logic [3:0] DIGIT_NINE = 4'h9;
	localparam logic [4:0] DIGIT_TEN  = 5'h0A;

	localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;

	// ---------------------------------------------------------------
	// Operations and states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		op_binary_add          = 2'h0,
		binary_subtract_opcode = 2'h1,
		op_decimal_add         = 2'h2
	} csau_op_t;

	// Gray codes along idle, read A, read B, capture A, write B, sign
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RDA  = 3'h1,
		ST_RDB  = 3'h3,
		ST_CAPA = 3'h2,
		ST_WRB  = 3'h6,
		ST_SIGN = 3'h7
	} csau_state_t;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0] zone;
		logic [3:0] digit;
	} csau_char_t;

	typedef struct packed {
		csau_op_t          op;
		logic [ADDR_W-1:0] a_addr;
		logic [ADDR_W-1:0] b_addr;
	} csau_cmd_t;

	typedef struct packed {
		logic              req;
		logic              we;
		logic [ADDR_W-1:0] addr;
		csau_char_t        wdata;
	} csau_mem_req_t;

	typedef struct packed {
		logic       wm;
		csau_char_t data;
	} csau_mem_rsp_t;

endpackage
`default_nettype wire

//--- csau_dec_digit.sv
`timescale 1ns/1ps
`default_nettype none
module csau_dec_digit (
	input  wire logic [3:0] a,
	input  wire logic [3:0] b,
	input  wire logic       comp,
	input  wire logic       cin,
	output logic      [3:0] sum,
	output logic            cout
);
	import csau_pkg::*;

	// ---------------------------------------------------------------
	// One decimal column, optionally nines-complementing a
	// ---------------------------------------------------------------
	logic [3:0] a_eff;
	logic [4:0] raw;
	logic [4:0] fixed;

	assign a_eff = comp ? (DIGIT_NINE - a) : a;
	assign raw   = {1'b0, b} + {1'b0, a_eff} + {4'h0, cin};
	assign cout  = (raw >= DIGIT_TEN);
	assign fixed = raw - DIGIT_TEN;
	assign sum   = cout ? fixed[3:0] : raw[3:0];

endmodule
`default_nettype wire

//--- csau_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module csau_mem_model (
	input  wire logic                    clk,
	input  wire csau_pkg::csau_mem_req_t mem_req,
	output csau_pkg::csau_mem_rsp_t      mem_rsp
);
	import csau_pkg::*;

	// ---------------------------------------------------------------
	// Character store with word marks
	// ---------------------------------------------------------------
	logic [CHAR_W-1:0] store_q [0:(1<<ADDR_W)-1];
	logic              mark_q  [0:(1<<ADDR_W)-1];

	// Read data is valid for one cycle only; otherwise the bus toggles so a
	// design that samples late sees garbage instead of a lucky stale value
	always @(posedge clk) begin
		if (mem_req.req && !mem_req.we) begin
			mem_rsp <= {mark_q[mem_req.addr], store_q[mem_req.addr]};
		end else begin
			mem_rsp <= ~mem_rsp;
		end
		// Writes carry no word mark, so the stored mark is kept
		if (mem_req.req && mem_req.we) begin
			store_q[mem_req.addr] <= mem_req.wdata;
		end
	end
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
	import csau_pkg::*;

	localparam logic [ADDR_W-1:0] A_UNITS = 15'h0100;
	localparam logic [ADDR_W-1:0] B_UNITS = 15'h0200;
	localparam int                LIMIT   = 40000;

	logic          clk     = 1'b0;
	logic          rst     = 1'b1;
	logic          start   = 1'b0;
	csau_cmd_t     cmd     = '0;
	logic          ovf_clr = 1'b0;
	csau_mem_rsp_t mem_rsp;
	csau_mem_req_t mem_req;
	logic          busy;
	logic          done;
	logic          ovf;
	int            n_mismatch = 0;
	int            cmp_count  = 0;
	int            cycles     = 0;
	int            a_ch [4];
	int            b_ch [4];
	int            exp_b [4];
	bit            exp_ovf = 1'b0;

	always #20 clk = ~clk;

	csau_unit csau_unit_i (
		.clk     (clk),
		.rst     (rst),
		.start   (start),
		.cmd     (cmd),
		.ovf_clr (ovf_clr),
		.mem_rsp (mem_rsp),
		.mem_req (mem_req),
		.busy    (busy),
		.done    (done),
		.ovf     (ovf)
	);

	csau_mem_model csau_mem_model_i (
		.clk     (clk),
		.mem_req (mem_req),
		.mem_rsp (mem_rsp)
	);

	// ---------------------------------------------------------------
	// Reference arithmetic on integers
	// ---------------------------------------------------------------
	task automatic model(input int op, input int na, input int nb);
		int c;
		int av;
		int s;
		int i;
		int sa;
		int sb;
		int zb;
		begin
			c = (op == 1) ? 1 : 0;
			if (op != 2) begin
				for (i = 0; i < nb; i++) begin
					av = (i < na) ? a_ch[i] : 0;
					if (op == 1) av = ~av & 63;
					s = av + b_ch[i] + c;
					exp_b[i] = s & 63;
					c = s >> 6;
				end
			end else begin
				sa = ((a_ch[0] >> 4) == 2);
				sb = ((b_ch[0] >> 4) == 2);
				c = (sa != sb);
				for (i = 0; i < nb; i++) begin
					av = (i < na) ? (a_ch[i] & 15) : 0;
					if (sa != sb) av = 9 - av;
					s = av + (b_ch[i] & 15) + c;
					exp_b[i] = s % 10;
					c = (s >= 10);
				end
				if (sa == sb) begin
					zb = b_ch[0] >> 4;
					if (c) exp_ovf = 1'b1;
				end else if (c) begin
					zb = sb ? 2 : 1;
				end else begin
					zb = sb ? 1 : 2;
					c = 1;
					for (i = 0; i < nb; i++) begin
						s = 9 - exp_b[i] + c;
						exp_b[i] = s % 10;
						c = (s >= 10);
					end
				end
				exp_b[0] = exp_b[0] | (zb << 4);
			end
		end
	endtask

	// ---------------------------------------------------------------
	// One operation: load fields, start, wait, compare
	// ---------------------------------------------------------------
	task automatic run_op(input int op, input int na, input int nb, input bit clr);
		int i;
		int k;
		int g;
		begin
			g = $urandom & 63;
			for (i = 0; i < 5; i++) begin
				csau_mem_model_i.store_q[A_UNITS - i] = 6'((i < na) ? a_ch[i] : $urandom);
				csau_mem_model_i.mark_q[A_UNITS - i] = (i == na - 1);
				csau_mem_model_i.store_q[B_UNITS - i] = 6'((i < nb) ? b_ch[i] : g);
				csau_mem_model_i.mark_q[B_UNITS - i] = (i == nb - 1);
			end
			if (clr) exp_ovf = 1'b0;
			model(op, na, nb);
			@(posedge clk);
			start <= 1'b1;
			ovf_clr <= clr;
			cmd <= '{op: csau_op_t'(2'(op)), a_addr: A_UNITS, b_addr: B_UNITS};
			@(posedge clk);
			start <= 1'b0;
			ovf_clr <= 1'b0;
			#1 `CHK("busy", 1'b1, busy)
			k = 0;
			// A second start in mid-operation with a stray command must be ignored
			do begin
				@(posedge clk);
				start <= (k == 0);
				if (k == 0) cmd <= csau_cmd_t'($urandom);
				#1;
				k++;
			end while (done !== 1'b1 && k < 200);
			`CHK("done", 1'b1, done)
			`CHK("busy_in_done", 1'b0, busy)
			@(posedge clk);
			#1;
			for (i = 0; i <= nb; i++) begin
				`CHK("b_field", 6'((i < nb) ? exp_b[i] : g), csau_mem_model_i.store_q[B_UNITS - i])
			end
			`CHK("ovf", exp_ovf, ovf)
		end
	endtask

	task automatic close_out;
		begin
			$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
			if (n_mismatch == 0 && cmp_count > 0) begin
				$display("TB: PASS");
			end else begin
				$display("TB: FAIL");
			end
			$finish;
		end
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_mismatch++;
			close_out();
		end
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		int op;
		int i;
		void'($urandom(32'h774C));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1 `CHK("rst_req", '0, mem_req)
		`CHK("rst_flags", 3'h0, {busy, done, ovf})
		// Two-character subtract of equal lengths, 87 minus 73
		a_ch = '{6'h09, 6'h01, 0, 0};
		b_ch = '{6'h17, 6'h01, 0, 0};
		run_op(1, 2, 2, 1'b0);
		repeat (300) begin
			// Code 3 is decoded as a binary add and is exercised as one
			op = $urandom % 4;
			for (i = 0; i < 4; i++) begin
				a_ch[i] = (op == 2) ? ((($urandom % 4) << 4) | ($urandom % 10)) : ($urandom & 63);
				b_ch[i] = (op == 2) ? ((($urandom % 4) << 4) | ($urandom % 10)) : ($urandom & 63);
			end
			run_op(op, 1 + $urandom % 4, 1 + $urandom % 4, ($urandom % 3) == 0);
		end
		close_out();
	end
endmodule
`default_nettype wire
